//--- hdl/tspk_packer.sv
`timescale 1ns/1ns
// Summary of operation
// [R1] frame layout on every lane follows the selected transport format
// [R2] sample index n orders samples in time, lower index first
// [R3] tail positions are sent as zero in every format
// [R4] samples are placed most significant bit first
// [R5] format 0: five 12-bit samples per lane frame, zero tail nibble 15
// [R6] format 0: lanes pair even/odd samples of A, B, then C, D on quad
// [R7] format 1: two-octet lane frames, A0 A1 B0 B1 packed across three lanes
// [R8] format 1: quad repeats for C, D; single zero-fills lane 1 octet 1
// [R9] lowest lanes are used; unused higher lanes are powered down
// [R10] all active lanes present their frame in the same cycle
module tspk_packer #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk, // frame clock
	input wire logic rstn, // async reset, active low
	input wire logic [3:0] transport_format_select, // transport format code
	input wire logic [1:0] dev_variant, // single, dual or quad
	input wire logic [11:0] smp_a, // channel a sample
	input wire logic [11:0] smp_b, // channel b sample
	input wire logic [11:0] smp_c, // channel c sample
	input wire logic [11:0] smp_d, // channel d sample
	input wire logic smp_valid, // one sample per channel offered
	output logic smp_ready, // samples accepted when high
	output logic [511:0] lane_frame, // lane k frame in bits 64k+63:64k
	output logic [7:0] lane_octets, // octets per lane frame
	output logic [7:0] lane_enable, // active lanes, others powered down
	output logic frame_valid, // frame presented on all lanes
	input wire logic frame_ready, // frame taken by the encoders
	output logic fmt_error // unsupported format selected
);
	localparam int SW = tspk_pkg::SAMPLE_W;
	localparam int WW = 4 * SW;
	localparam int LW = tspk_pkg::LANE_FRAME_W;

	initial begin
		if (FIFO_DEPTH != 16) begin
			$error("tspk_packer is built for a sample buffer of 16 words");
		end
		if (SW != 12) begin
			$error("tspk_packer lane maps are laid out for 12-bit samples");
		end
		if (tspk_pkg::M0_SAMPLES * SW + $bits(tspk_pkg::TAIL_NIBBLE) != LW) begin
			$error("tspk_packer format 0 lane must hold five samples and a tail nibble");
		end
		if (tspk_pkg::M0_OCTETS * tspk_pkg::OCTET_W != LW) begin
			$error("tspk_packer lane word must be one format 0 frame wide");
		end
		if (tspk_pkg::LANES * LW != $bits(lane_frame)) begin
			$error("tspk_packer lane_frame must hold every lane word");
		end
	end

	// ****************************************
	// sample buffer
	// ****************************************
	logic [WW-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;

	tspk_fifo #(
		.WIDTH(WW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.wr_data({smp_a, smp_b, smp_c, smp_d}),
		.wr_valid(smp_valid),
		.wr_ready(smp_ready),
		.rd_data(fifo_data),
		.rd_valid(fifo_valid),
		.rd_ready(fifo_pop)
	);

	// ****************************************
	// format decode
	// ****************************************
	function automatic logic [3:0] samples_per_frame(input logic [3:0] fmt);
		if (fmt == tspk_pkg::FMT_MODE0) begin
			samples_per_frame = 4'(tspk_pkg::M0_PER_CH);
		end else begin
			samples_per_frame = 4'(tspk_pkg::M1_SAMPLES);
		end
	endfunction : samples_per_frame

	function automatic logic [7:0] lanes_used(input logic [3:0] fmt, input logic [1:0] dev);
		lanes_used = 8'h00;
		if (fmt == tspk_pkg::FMT_MODE0) begin
			if (dev == tspk_pkg::DEV_QUAD) begin
				lanes_used = tspk_pkg::M0_LANES_QUAD;
			end else if (dev == tspk_pkg::DEV_DUAL) begin
				lanes_used = tspk_pkg::M0_LANES_DUAL;
			end else begin
				lanes_used = tspk_pkg::M0_LANES_SINGLE;
			end
		end else if (fmt == tspk_pkg::FMT_MODE1) begin
			if (dev == tspk_pkg::DEV_QUAD) begin
				lanes_used = tspk_pkg::M1_LANES_QUAD;
			end else if (dev == tspk_pkg::DEV_DUAL) begin
				lanes_used = tspk_pkg::M1_LANES_DUAL;
			end else begin
				lanes_used = tspk_pkg::M1_LANES_SINGLE;
			end
		end
	endfunction : lanes_used

	// format is latched at the start of each frame so a change never splits a frame
	logic [3:0] fmt_q;
	logic [1:0] dev_q;
	logic fmt_ok;

	assign fmt_ok = (transport_format_select == tspk_pkg::FMT_MODE0)
		|| (transport_format_select == tspk_pkg::FMT_MODE1);

	// ****************************************
	// frame assembly state
	// ****************************************
	tspk_pkg::tspk_state_t state_q;
	logic [3:0] idx_q;
	logic [SW-1:0] buf_a_q [tspk_pkg::M0_PER_CH];
	logic [SW-1:0] buf_b_q [tspk_pkg::M0_PER_CH];
	logic [SW-1:0] buf_c_q [tspk_pkg::M0_PER_CH];
	logic [SW-1:0] buf_d_q [tspk_pkg::M0_PER_CH];
	logic last_smp;
	logic emit_done;

	assign fifo_pop = fifo_valid && (state_q == tspk_pkg::TSPK_FILL);
	assign last_smp = idx_q == samples_per_frame(fmt_q) - 4'h1;
	assign emit_done = frame_valid && frame_ready;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= tspk_pkg::TSPK_IDLE;
		end else begin
			case (state_q)
				tspk_pkg::TSPK_IDLE: begin
					if (fmt_ok) begin
						state_q <= tspk_pkg::TSPK_FILL;
					end
				end
				tspk_pkg::TSPK_FILL: begin
					if (fifo_pop && last_smp) begin
						state_q <= tspk_pkg::TSPK_EMIT;
					end
				end
				tspk_pkg::TSPK_EMIT: begin
					if (emit_done) begin
						state_q <= tspk_pkg::TSPK_IDLE;
					end
				end
				default: begin
					state_q <= tspk_pkg::TSPK_IDLE;
				end
			endcase
		end
	end

	logic frame_start;

	// format and variant are taken only here, so one frame never mixes two layouts
	assign frame_start = state_q == tspk_pkg::TSPK_IDLE && fmt_ok;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fmt_q <= tspk_pkg::FMT_MODE0;
		end else if (frame_start) begin
			fmt_q <= transport_format_select; // [R1]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dev_q <= tspk_pkg::DEV_SINGLE;
		end else if (frame_start) begin
			dev_q <= dev_variant;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idx_q <= 4'h0;
		end else if (state_q == tspk_pkg::TSPK_IDLE) begin
			idx_q <= 4'h0;
		end else if (fifo_pop) begin
			idx_q <= idx_q + 4'h1; // [R2]
		end
	end

	// samples are stored by index so index 0 is the earliest in time
	always_ff @(posedge clk) begin
		if (fifo_pop) begin
			buf_a_q[idx_q] <= fifo_data[4*SW-1:3*SW]; // [R2]
			buf_b_q[idx_q] <= fifo_data[3*SW-1:2*SW];
			buf_c_q[idx_q] <= fifo_data[2*SW-1:SW];
			buf_d_q[idx_q] <= fifo_data[SW-1:0];
		end
	end

	// ****************************************
	// lane mapping
	// ****************************************
	// format 0 lane: five samples of one parity, msb first, zero tail nibble
	function automatic logic [63:0] m0_lane(
		input logic [SW-1:0] s0, input logic [SW-1:0] s1, input logic [SW-1:0] s2,
		input logic [SW-1:0] s3, input logic [SW-1:0] s4);
		m0_lane = {s0, s1, s2, s3, s4, tspk_pkg::TAIL_NIBBLE}; // [R3] [R4] [R5]
	endfunction : m0_lane

	// format 1 three-lane group, octets in bits 63:48 of each lane word
	function automatic logic [191:0] m1_group(
		input logic [SW-1:0] p0, input logic [SW-1:0] p1,
		input logic [SW-1:0] q0, input logic [SW-1:0] q1, input logic zero_q);
		logic [15:0] l0;
		logic [15:0] l1;
		logic [15:0] l2;
		l0 = {p0, p1[11:8]}; // [R4] [R7]
		l1 = {p1[7:0], zero_q ? tspk_pkg::FILL_OCTET : q0[11:4]}; // [R7] [R8]
		l2 = {q0[3:0], q1}; // [R7]
		m1_group = {l2, 48'h0, l1, 48'h0, l0, 48'h0};
	endfunction : m1_group

	logic [511:0] frame_d;
	logic single_dev;
	logic [7:0] lanes_on;

	assign single_dev = dev_q == tspk_pkg::DEV_SINGLE;
	// lowest lanes first; the mask also drives the power-down of the rest
	assign lanes_on = lanes_used(fmt_q, dev_q); // [R9]

	always_comb begin
		frame_d = '0;
		if (fmt_q == tspk_pkg::FMT_MODE0) begin
			frame_d[63:0] = m0_lane(buf_a_q[0], buf_a_q[2], buf_a_q[4], buf_a_q[6], buf_a_q[8]); // [R6]
			frame_d[127:64] = m0_lane(buf_a_q[1], buf_a_q[3], buf_a_q[5], buf_a_q[7], buf_a_q[9]);
			frame_d[191:128] = m0_lane(buf_b_q[0], buf_b_q[2], buf_b_q[4], buf_b_q[6], buf_b_q[8]);
			frame_d[255:192] = m0_lane(buf_b_q[1], buf_b_q[3], buf_b_q[5], buf_b_q[7], buf_b_q[9]);
			frame_d[319:256] = m0_lane(buf_c_q[0], buf_c_q[2], buf_c_q[4], buf_c_q[6], buf_c_q[8]);
			frame_d[383:320] = m0_lane(buf_c_q[1], buf_c_q[3], buf_c_q[5], buf_c_q[7], buf_c_q[9]);
			frame_d[447:384] = m0_lane(buf_d_q[0], buf_d_q[2], buf_d_q[4], buf_d_q[6], buf_d_q[8]);
			frame_d[511:448] = m0_lane(buf_d_q[1], buf_d_q[3], buf_d_q[5], buf_d_q[7], buf_d_q[9]);
		end else begin
			frame_d[191:0] = m1_group(buf_a_q[0], buf_a_q[1], buf_b_q[0], buf_b_q[1], single_dev);
			frame_d[383:192] = m1_group(buf_c_q[0], buf_c_q[1], buf_d_q[0], buf_d_q[1], 1'b0); // [R8]
		end
		// unused lanes carry zeros; they are powered down anyway
		for (int k = 0; k < tspk_pkg::LANES; k++) begin
			if (!lanes_on[k]) begin
				frame_d[k*64 +: 64] = '0; // [R9]
			end
		end
	end

	// ****************************************
	// output registers
	// ****************************************
	logic frame_load;

	// the lane word is loaded on the first emit cycle, once the last sample sits in the buffer
	assign frame_load = state_q == tspk_pkg::TSPK_EMIT && !frame_valid;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lane_frame <= '0;
		end else if (frame_load) begin
			lane_frame <= frame_d; // [R10]
		end
	end

	// valid rises with the lane word and holds it still until the encoders take it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			frame_valid <= 1'b0;
		end else if (frame_load) begin
			frame_valid <= 1'b1; // [R10]
		end else if (emit_done) begin
			frame_valid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lane_enable <= 8'h00;
		end else begin
			lane_enable <= lanes_on; // [R9]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lane_octets <= 8'h00;
		end else begin
			lane_octets <= (fmt_q == tspk_pkg::FMT_MODE0) ? 8'(tspk_pkg::M0_OCTETS)
				: 8'(tspk_pkg::M1_OCTETS);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fmt_error <= 1'b0;
		end else begin
			fmt_error <= !fmt_ok;
		end
	end
endmodule : tspk_packer

//--- hdl/tspk_pkg.sv
package tspk_pkg;
	// ****************************************
	// transport format codes
	// ****************************************
	localparam logic [3:0] FMT_MODE0 = 4'h0;
	localparam logic [3:0] FMT_MODE1 = 4'h1;

	// ****************************************
	// frame geometry
	// ****************************************
	localparam int SAMPLE_W = 12;
	localparam int LANES = 8;
	localparam int OCTET_W = 8;
	localparam int M0_OCTETS = 8;
	localparam int M0_SAMPLES = 5;
	localparam int M1_OCTETS = 2;
	localparam int M1_SAMPLES = 2;
	localparam int M0_PER_CH = 10;
	localparam int LANE_FRAME_W = 64;
	localparam int FRAME_W = LANES * LANE_FRAME_W;
	localparam logic [3:0] TAIL_NIBBLE = 4'h0;
	localparam logic [7:0] FILL_OCTET = 8'h00;

	// ****************************************
	// device variants
	// ****************************************
	localparam logic [1:0] DEV_SINGLE = 2'h0;
	localparam logic [1:0] DEV_DUAL = 2'h1;
	localparam logic [1:0] DEV_QUAD = 2'h2;

	// ****************************************
	// lane usage per mode and variant
	// ****************************************
	localparam logic [7:0] M0_LANES_QUAD = 8'hFF;
	localparam logic [7:0] M0_LANES_DUAL = 8'h0F;
	localparam logic [7:0] M0_LANES_SINGLE = 8'h03;
	localparam logic [7:0] M1_LANES_QUAD = 8'h3F;
	localparam logic [7:0] M1_LANES_DUAL = 8'h07;
	localparam logic [7:0] M1_LANES_SINGLE = 8'h03;

	typedef enum logic [1:0] {
		TSPK_IDLE = 2'b00,
		TSPK_FILL = 2'b01,
		TSPK_EMIT = 2'b11
	} tspk_state_t;
endpackage : tspk_pkg

//--- hdl/tspk_fifo.sv
`timescale 1ns/1ns
module tspk_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
) (
	input wire logic clk, // frame clock
	input wire logic rstn, // async reset, active low
	input wire logic [WIDTH-1:0] wr_data, // word in
	input wire logic wr_valid, // word offered
	output logic wr_ready, // room for a word
	output logic [WIDTH-1:0] rd_data, // head word
	output logic rd_valid, // head word present
	input wire logic rd_ready // head word taken
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin
			$error("tspk_fifo depth must be a power of two of at least 2");
		end
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr_q;
	logic [AW:0] rptr_q;
	logic push;
	logic pop;
	logic [AW:0] wptr_d;
	logic [AW:0] rptr_d;
	logic ready_q;

	// ready is registered from the next pointers, so it never lags a push or a pop
	assign wr_ready = ready_q;
	assign wptr_d = push ? wptr_q + (AW+1)'(1) : wptr_q;
	assign rptr_d = pop ? rptr_q + (AW+1)'(1) : rptr_q;
	assign rd_valid = wptr_q != rptr_q;
	assign rd_data = mem[rptr_q[AW-1:0]];
	assign push = wr_valid && wr_ready;
	assign pop = rd_valid && rd_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr_q[AW-1:0]] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wptr_q <= '0;
		end else if (push) begin
			wptr_q <= wptr_q + (AW+1)'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rptr_q <= '0;
		end else if (pop) begin
			rptr_q <= rptr_q + (AW+1)'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ready_q <= 1'b1;
		end else begin
			ready_q <= (wptr_d - rptr_d) != (AW+1)'(DEPTH);
		end
	end
endmodule : tspk_fifo

//--- sim/tspk_chk.sv
`timescale 1ns/1ns
// ****
// frame checks at the lane side
// ****
module tspk_chk (
	input wire logic clk, // clock
	input wire logic rstn, // reset
	input wire logic [3:0] transport_format_select, // format
	input wire logic smp_valid, // offer
	input wire logic smp_ready, // room
	input wire logic [511:0] lane_frame, // lanes
	input wire logic [7:0] lane_octets, // octets
	input wire logic [7:0] lane_enable, // lanes on
	input wire logic frame_valid, // frame
	input wire logic frame_ready, // taken
	input wire logic fmt_error // bad format
);
	logic tk;
	logic tl;
	logic lo;
	logic of;
	assign tk = frame_valid && frame_ready;
	always_comb begin
		tl = 1'b0;
		lo = 1'b0;
		of = 1'b0;
		for (int k = 0; k < 8; k++) begin
			tl |= lane_enable[k] && lane_frame[64*k+:4] != 4'h0;
			lo |= lane_enable[k] && lane_frame[64*k+:48] != 48'h0;
			of |= !lane_enable[k] && lane_frame[64*k+:64] != 64'h0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_tail_zero: assert property (tk && lane_octets == 8'h08 |-> !tl)
		else $error("tail nibble not zero");
	a_short_unused: assert property (tk && lane_octets == 8'h02 |-> !lo)
		else $error("short frame low bits not zero");
	a_single_fill: assert property (
		tk && lane_octets == 8'h02 && lane_enable == 8'h03 |-> lane_frame[119:112] == 8'h00)
		else $error("single fill octet not zero");
	a_lane_set: assert property (frame_valid |->
		(lane_octets == 8'h08 && lane_enable inside {8'h03, 8'h0F, 8'hFF}) ||
		(lane_octets == 8'h02 && lane_enable inside {8'h03, 8'h07, 8'h3F}))
		else $error("lane set does not fit format");
	a_off_zero: assert property (tk |-> !of)
		else $error("disabled lane not zero");
	a_hold_frame: assert property (
		frame_valid && !frame_ready |=> frame_valid && $stable(lane_enable)
		&& $stable(lane_frame))
		else $error("frame dropped before taken");
	a_err_idle: assert property (fmt_error |-> !frame_valid)
		else $error("frame sent on bad format");
	a_err_cause: assert property ($rose(fmt_error) |->
		$past(transport_format_select) > 4'h1 || $past(transport_format_select, 2) > 4'h1)
		else $error("format error without cause");
	c_long: cover property (tk && lane_octets == 8'h08);
	c_short: cover property (tk && lane_octets == 8'h02);
	c_full: cover property (smp_valid && !smp_ready);
endmodule : tspk_chk
bind tspk_packer tspk_chk i_chk (.clk(clk), .rstn(rstn),
	.transport_format_select(transport_format_select), .smp_valid(smp_valid),
	.smp_ready(smp_ready), .lane_frame(lane_frame), .lane_octets(lane_octets),
	.lane_enable(lane_enable), .frame_valid(frame_valid), .frame_ready(frame_ready),
	.fmt_error(fmt_error));

//--- sim/tspk_enc_model.sv
`timescale 1ns/1ns
// ****
// lane encoder stand-in
// ****
module tspk_enc_model (
	input wire logic clk, // clock
	input wire logic rstn, // reset
	input wire logic frame_valid, // frame offered
	input wire logic stall, // slow take
	output logic frame_ready // frame taken
);
	logic seen_q;
	// one cycle of wait after the rise; the lane word already lands on the same edge as valid
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= frame_valid && !frame_ready;
		end
	end
	assign frame_ready = seen_q && !stall;
endmodule : tspk_enc_model

//--- sim/testbench.sv
`timescale 1ns/1ns
// ****
// bench
// ****
module testbench;
	logic clk, rstn, smp_valid, stall, smp_ready, frame_valid, frame_ready, fmt_error, r;
	logic [3:0] fmt;
	logic [1:0] dv;
	logic [11:0] sa, sb, sc, sd;
	logic [511:0] lane_frame;
	logic [7:0] lane_octets, lane_enable;
	logic [9:0] seq;
	logic [47:0] q[$];
	int failures, n_tests, acc;
	tspk_packer #(.FIFO_DEPTH(16)) i_dut (.clk(clk), .rstn(rstn),
		.transport_format_select(fmt), .dev_variant(dv), .smp_a(sa), .smp_b(sb),
		.smp_c(sc), .smp_d(sd), .smp_valid(smp_valid), .smp_ready(smp_ready),
		.lane_frame(lane_frame), .lane_octets(lane_octets), .lane_enable(lane_enable),
		.frame_valid(frame_valid), .frame_ready(frame_ready), .fmt_error(fmt_error));
	tspk_enc_model i_enc (.clk(clk), .rstn(rstn), .frame_valid(frame_valid),
		.stall(stall), .frame_ready(frame_ready));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic give_verdict();
		if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic chk(string nm, logic [511:0] e, logic [511:0] s);
		n_tests++;
		if (e !== s) begin
			failures++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	// each channel carries its id in the top bits so swaps show up
	task automatic offer(output logic rd);
		sa = {2'h0, seq};
		sb = {2'h1, seq};
		sc = {2'h2, seq};
		sd = {2'h3, seq};
		smp_valid = 1'b1;
		rd = smp_ready;
		@(posedge clk);
		if (rd === 1'b1) begin
			q.push_back({sa, sb, sc, sd});
			seq++;
		end
		#1;
	endtask : offer
	task automatic send(int n);
		int t;
		for (int i = 0; i < n; i++) begin
			t = 0;
			do begin
				offer(r);
				t++;
			end while (r !== 1'b1 && t < 400);
			if (t >= 400) begin
				failures++;
				give_verdict();
			end
		end
		smp_valid = 1'b0;
	endtask : send
	task automatic wait_idle();
		int t;
		t = 0;
		while ((q.size() > 0 || frame_valid !== 1'b0) && t < 400) begin
			@(posedge clk);
			#1;
			t++;
		end
		if (t >= 400) begin
			failures++;
			give_verdict();
		end
	endtask : wait_idle
	task automatic check_frame();
		logic [47:0] f[10];
		logic [47:0] w;
		logic [511:0] e;
		logic [7:0] en;
		int n;
		n = (fmt == 4'h0) ? 10 : 2;
		e = '0;
		for (int i = 0; i < n; i++) f[i] = (q.size() > 0) ? q.pop_front() : 48'h0;
		en = (fmt == 4'h0) ? (dv == 2'h2 ? 8'hFF : dv == 2'h1 ? 8'h0F : 8'h03) :
			(dv == 2'h2 ? 8'h3F : dv == 2'h1 ? 8'h07 : 8'h03);
		for (int c = 0; c < 4; c++) begin
			if (fmt == 4'h0) begin
				for (int p = 0; p < 2; p++) e[128*c+64*p+:64] = {f[p][47-12*c-:12],
					f[p+2][47-12*c-:12], f[p+4][47-12*c-:12], f[p+6][47-12*c-:12],
					f[p+8][47-12*c-:12], 4'h0};
			end else if (c < 2) begin
				w = {f[0][47-24*c-:12], f[1][47-24*c-:12], f[0][35-24*c-:12], f[1][35-24*c-:12]};
				e[192*c+48+:16] = w[47:32];
				e[192*c+112+:16] = w[31:16];
				e[192*c+176+:16] = w[15:0];
			end
		end
		if (fmt != 4'h0 && dv == 2'h0) e[119:112] = 8'h00;
		for (int k = 0; k < 8; k++) if (!en[k]) e[64*k+:64] = '0;
		chk("lane_frame", e, lane_frame);
		chk("lane_enable", 512'(en), 512'(lane_enable));
		chk("lane_octets", 512'(n == 10 ? 8 : 2), 512'(lane_octets));
	endtask : check_frame
	always @(posedge clk) begin
		if (frame_valid === 1'b1 && frame_ready === 1'b1) check_frame();
	end
	task automatic t_formats();
		for (int f = 0; f < 2; f++) begin
			for (int d = 0; d < 3; d++) begin
				fmt = 4'(f);
				dv = 2'(d);
				send(f == 0 ? 20 : 4);
				wait_idle();
			end
		end
	endtask : t_formats
	task automatic t_stall();
		fmt = 4'h1;
		dv = 2'h2;
		stall = 1'b1;
		acc = 0;
		for (int i = 0; i < 30; i++) begin
			offer(r);
			if (r === 1'b1) acc++;
		end
		smp_valid = 1'b0;
		chk("smp_ready", 512'(0), 512'(r));
		chk("accepted", 512'(1), 512'(acc >= 16));
		stall = 1'b0;
		wait_idle();
	endtask : t_stall
	task automatic t_bad_format();
		fmt = 4'h2;
		repeat (6) @(posedge clk);
		#1;
		chk("fmt_error", 512'(1), 512'(fmt_error));
		chk("frame_valid", 512'(0), 512'(frame_valid));
		fmt = 4'h0;
		repeat (6) @(posedge clk);
		#1;
		chk("fmt_error", 512'(0), 512'(fmt_error));
	endtask : t_bad_format
	initial begin
		{rstn, smp_valid, stall, fmt, dv, sa, sb, sc, sd, seq} = '0;
		failures = 0;
		n_tests = 0;
		repeat (10) @(posedge clk);
		#1 rstn = 1'b1;
		t_formats();
		t_stall();
		t_bad_format();
		give_verdict();
	end
endmodule : testbench
